// ### pkg/prog_pkg.sv
// Constants shared by the programmer host port map: port offsets, bit positions, reset values.
// Assumes the host addresses the programmer through 16-bit I/O port numbers.
package prog_pkg;
  localparam logic [15:0] PORT_DATA = 16'h00f0;
  localparam logic [15:0] PORT_CTRL = 16'h00f1;
  localparam logic [15:0] PORT_LOW = 16'h00f2;
  localparam int NIBBLE_BIT = 4;
  localparam int SOCKET_BIT = 5;
  localparam int START_RD_BIT = 6;
  localparam int HIGH_ADDR_MSB = 3;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [3:0] NIBBLE_RESET = 4'h0;
  localparam logic [4:0] ERR_RESET = 5'h00;
  localparam logic [15:0] ADDR_PIN_RESET = 16'hffff;
endpackage : prog_pkg

// ### pkg/host_port_if.sv
// Decoded host port accesses passed from the port decoder to the register core.
// Assumes both ends run on mclk; strobes are one-cycle pulses, selects are levels.
`timescale 1ns/1ps
interface host_port_if;
  logic wr_data_stb;
  logic wr_ctrl_stb;
  logic wr_low_stb;
  logic rd_data_sel;
  logic rd_status_sel;
  logic [7:0] wdata;
  modport dec (output wr_data_stb, wr_ctrl_stb, wr_low_stb, rd_data_sel, rd_status_sel, wdata);
  modport core (input wr_data_stb, wr_ctrl_stb, wr_low_stb, rd_data_sel, rd_status_sel, wdata);
endinterface : host_port_if

// ### hw/port_decoder.sv
// Synchronises the host port pins and decodes them into register strobes.
// Assumes the host holds address and data stable around its active-low strobes.
`timescale 1ns/1ps
module port_decoder (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  // Host pins, active low except io_addr
  input wire logic [15:0] io_addr,
  input wire logic io_rd_n,
  input wire logic io_wr_n,
  input wire logic [7:0] host_write_bus_n,
  // Decoded accesses
  host_port_if.dec bus
);
  typedef struct packed {
    logic [15:0] addr_s1;
    logic [15:0] addr_s2;
    logic [7:0] data_s1;
    logic [7:0] data_s2;
    logic rd_n_s1;
    logic rd_n_s2;
    logic wr_n_s1;
    logic wr_n_s2;
    logic wr_n_s3;
  } sync_state_t;

  sync_state_t s_reg;
  sync_state_t s_next;
  logic wr_fall;

  // Two-stage synchronisers, third stage only for edge detection
  always_comb begin
    s_next = s_reg;
    s_next.addr_s1 = io_addr;
    s_next.addr_s2 = s_reg.addr_s1;
    s_next.data_s1 = host_write_bus_n;
    s_next.data_s2 = s_reg.data_s1;
    s_next.rd_n_s1 = io_rd_n;
    s_next.rd_n_s2 = s_reg.rd_n_s1;
    s_next.wr_n_s1 = io_wr_n;
    s_next.wr_n_s2 = s_reg.wr_n_s1;
    s_next.wr_n_s3 = s_reg.wr_n_s2;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_reg <= '{addr_s1: prog_pkg::ADDR_PIN_RESET, addr_s2: prog_pkg::ADDR_PIN_RESET,
                 data_s1: 8'hff, data_s2: 8'hff, rd_n_s1: 1'b1, rd_n_s2: 1'b1,
                 wr_n_s1: 1'b1, wr_n_s2: 1'b1, wr_n_s3: 1'b1};
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  // Decode only the three mapped offsets
  assign wr_fall = s_reg.wr_n_s3 & ~s_reg.wr_n_s2;
  assign bus.wr_data_stb = wr_fall && (s_reg.addr_s2 == prog_pkg::PORT_DATA);
  assign bus.wr_ctrl_stb = wr_fall && (s_reg.addr_s2 == prog_pkg::PORT_CTRL);
  assign bus.wr_low_stb = wr_fall && (s_reg.addr_s2 == prog_pkg::PORT_LOW);
  assign bus.rd_data_sel = !s_reg.rd_n_s2 && (s_reg.addr_s2 == prog_pkg::PORT_DATA);
  assign bus.rd_status_sel = !s_reg.rd_n_s2 && (s_reg.addr_s2 == prog_pkg::PORT_CTRL);
  assign bus.wdata = ~s_reg.data_s2;
endmodule : port_decoder

// ### hw/programmer_port_map.sv
// Host-visible port map of the PROM programmer: write, control/address and low address
// registers, status byte and read-back path.
// Assumes an internal controller on mclk that performs PROM reads and programming.
`timescale 1ns/1ps
module programmer_port_map (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  // Host port pins, active low except io_addr
  input wire logic [15:0] io_addr,
  input wire logic io_rd_n,
  input wire logic io_wr_n,
  input wire logic [7:0] host_write_bus_n,
  output logic [7:0] host_read_bus_n,
  output logic read_ack_n,
  // Towards the PROM controller
  output logic [7:0] prom_write_data,
  output logic [11:0] prom_address,
  output logic [3:0] program_nibble,
  output logic nibble_select,
  output logic socket1_select,
  output logic socket2_select,
  output logic read_prom_req,
  output logic write_prom_req,
  // From the PROM controller
  input wire logic ctl_read_done,
  input wire logic [7:0] ctl_read_data,
  input wire logic ctl_prog_done,
  input wire logic program_done_ok,
  input wire logic program_failure,
  input wire logic [4:0] ctl_errors
);
  typedef struct packed {
    logic [7:0] wdata;
    logic [3:0] high;
    logic [7:0] low;
    logic nib;
    logic sock;
    logic rd_req;
    logic wr_req;
    logic ok;
    logic fail;
    logic [4:0] err;
    logic [7:0] rdata;
    logic [7:0] rbus_n;
    logic ack_n;
    logic [3:0] prog_nib;
  } core_state_t;

  core_state_t s_reg;
  core_state_t s_next;
  logic [7:0] status_byte;

  host_port_if bus ();

  port_decoder u_dec (
    .mclk(mclk),
    .resetn(resetn),
    .ce(ce),
    .io_addr(io_addr),
    .io_rd_n(io_rd_n),
    .io_wr_n(io_wr_n),
    .host_write_bus_n(host_write_bus_n),
    .bus(bus)
  );

  // Status byte: errors, failure, done, busy from D7 down to D0
  assign status_byte = {s_reg.err, s_reg.fail, s_reg.ok, s_reg.rd_req | s_reg.wr_req};

  // Next state: controller completions first, host strobes after so a set wins
  always_comb begin
    s_next = s_reg;
    if (ctl_read_done) begin
      s_next.rd_req = 1'b0;
      s_next.rdata = ctl_read_data;
      s_next.err = ctl_errors;
    end
    if (ctl_prog_done) begin
      s_next.wr_req = 1'b0;
      s_next.ok = program_done_ok;
      s_next.fail = program_failure;
      s_next.err = ctl_errors;
    end
    if (bus.wr_data_stb) begin
      s_next.wdata = bus.wdata;
      s_next.wr_req = 1'b1;
      s_next.ok = 1'b0;
      s_next.fail = 1'b0;
    end
    if (bus.wr_ctrl_stb) begin
      s_next.high = bus.wdata[prog_pkg::HIGH_ADDR_MSB:0];
      s_next.nib = bus.wdata[prog_pkg::NIBBLE_BIT];
      s_next.sock = bus.wdata[prog_pkg::SOCKET_BIT];
      if (bus.wdata[prog_pkg::START_RD_BIT]) begin
        s_next.rd_req = 1'b1;
        s_next.ok = 1'b0;
        s_next.fail = 1'b0;
      end
    end
    if (bus.wr_low_stb) begin
      s_next.low = bus.wdata;
    end
    // Nibble to program follows the select bit
    s_next.prog_nib = s_next.nib ? s_next.wdata[3:0] : s_next.wdata[7:4];
    // Read bus carries data while F0 is read, status otherwise, inverted on the pins
    s_next.rbus_n = ~(bus.rd_data_sel ? s_reg.rdata : status_byte);
    s_next.ack_n = ~(bus.rd_data_sel | bus.rd_status_sel);
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_reg <= '{wdata: prog_pkg::BYTE_RESET, high: prog_pkg::NIBBLE_RESET,
                 low: prog_pkg::BYTE_RESET, nib: 1'b0, sock: 1'b0, rd_req: 1'b0,
                 wr_req: 1'b0, ok: 1'b0, fail: 1'b0, err: prog_pkg::ERR_RESET,
                 rdata: prog_pkg::BYTE_RESET, rbus_n: 8'hff, ack_n: 1'b1,
                 prog_nib: prog_pkg::NIBBLE_RESET};
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state
  assign host_read_bus_n = s_reg.rbus_n;
  assign read_ack_n = s_reg.ack_n;
  assign prom_write_data = s_reg.wdata;
  assign prom_address = {s_reg.high, s_reg.low};
  assign program_nibble = s_reg.prog_nib;
  assign nibble_select = s_reg.nib;
  assign socket1_select = s_reg.sock;
  assign socket2_select = ~s_reg.sock;
  assign read_prom_req = s_reg.rd_req;
  assign write_prom_req = s_reg.wr_req;

  // Checks on the port map
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence s_start_read;
    ce && bus.wr_ctrl_stb && bus.wdata[prog_pkg::START_RD_BIT];
  endsequence

  sequence s_busy_read;
    read_prom_req && status_byte[0];
  endsequence

  property p_read_data;
    ce && bus.rd_data_sel |=> host_read_bus_n == ~$past(s_reg.rdata);
  endproperty
  a_read_data: assert property (p_read_data) else $error("data read not on bus");

  property p_read_status;
    ce && !bus.rd_data_sel |=> host_read_bus_n == ~$past(status_byte);
  endproperty
  a_read_status: assert property (p_read_status) else $error("status not on bus");

  property p_write_data;
    ce && bus.wr_data_stb |=> prom_write_data == $past(bus.wdata) && write_prom_req;
  endproperty
  a_write_data: assert property (p_write_data) else $error("write byte not loaded");

  property p_high_addr;
    ce && bus.wr_ctrl_stb |=> prom_address[11:8] == $past(bus.wdata[3:0]);
  endproperty
  a_high_addr: assert property (p_high_addr) else $error("high address not loaded");

  property p_mode_bits;
    ce && bus.wr_ctrl_stb |=> nibble_select == $past(bus.wdata[4]) && socket1_select == $past(bus.wdata[5]);
  endproperty
  a_mode_bits: assert property (p_mode_bits) else $error("mode bits not loaded");

  property p_low_addr;
    ce && bus.wr_low_stb |=> prom_address[7:0] == $past(bus.wdata);
  endproperty
  a_low_addr: assert property (p_low_addr) else $error("low address not loaded");

  property p_unmapped;
    !(bus.wr_data_stb || bus.wr_ctrl_stb || bus.wr_low_stb) |=> $stable(prom_address) && $stable(prom_write_data);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("state changed without strobe");

  property p_ack_low;
    ce && (bus.rd_data_sel || bus.rd_status_sel) |=> !read_ack_n;
  endproperty
  a_ack_low: assert property (p_ack_low) else $error("acknowledge not driven low");

  // Nibble comes from the byte just latched, picked by the held select bit
  property p_nibble;
    ce && bus.wr_data_stb |=>
      program_nibble == (nibble_select ? $past(bus.wdata[3:0]) : $past(bus.wdata[7:4]));
  endproperty
  a_nibble: assert property (p_nibble) else $error("wrong nibble to program");

  property p_socket;
    socket1_select != socket2_select;
  endproperty
  a_socket: assert property (p_socket) else $error("both or no socket selected");

  property p_start_read;
    s_start_read |=> s_busy_read;
  endproperty
  a_start_read: assert property (p_start_read) else $error("start read did not set busy");

  // Controller completions with no host set in the same cycle
  sequence s_read_finish;
    ce && ctl_read_done && !(bus.wr_ctrl_stb && bus.wdata[prog_pkg::START_RD_BIT]);
  endsequence

  sequence s_prog_finish;
    ce && ctl_prog_done && !bus.wr_data_stb && !(bus.wr_ctrl_stb && bus.wdata[prog_pkg::START_RD_BIT]);
  endsequence

  // A finished read drops the request and latches the byte
  property p_read_finish;
    s_read_finish |=> !read_prom_req && s_reg.rdata == $past(ctl_read_data);
  endproperty
  a_read_finish: assert property (p_read_finish) else $error("read completion not taken");

  // A finished program operation reports its outcome in the status byte
  property p_prog_finish;
    s_prog_finish |=> !write_prom_req && status_byte[2:1] == {$past(program_failure), $past(program_done_ok)}
      && status_byte[7:3] == $past(ctl_errors);
  endproperty
  a_prog_finish: assert property (p_prog_finish) else $error("program outcome not in status");

  // No acknowledge for reads outside the mapped ports
  property p_unmapped_ack;
    ce && !(bus.rd_data_sel || bus.rd_status_sel) |=> read_ack_n;
  endproperty
  a_unmapped_ack: assert property (p_unmapped_ack) else $error("acknowledge without mapped read");

  // Busy shows at once after a program data write
  property p_write_busy;
    ce && bus.wr_data_stb |=> status_byte[0];
  endproperty
  a_write_busy: assert property (p_write_busy) else $error("write did not set busy");
endmodule : programmer_port_map

// ### verif/prom_ctl_model.sv
// PROM controller model: answers read and program requests after a delay.
// Assumes same-clock requests held high until their done pulse.
`timescale 1ns/1ps
module prom_ctl_model #(parameter int DLY = 30) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Requests
  input wire logic read_prom_req,
  input wire logic write_prom_req,
  input wire logic [11:0] prom_address,
  input wire logic fail_mode,
  // Answers
  output logic ctl_read_done,
  output logic [7:0] ctl_read_data,
  output logic ctl_prog_done,
  output logic program_done_ok,
  output logic program_failure,
  output logic [4:0] ctl_errors
);
  int cnt;
  // One done pulse per request, none for a program request that overlaps a read; read data churns outside the pulse
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt <= 0;
      ctl_read_done <= 1'b0;
      ctl_prog_done <= 1'b0;
      ctl_read_data <= 8'h00;
    end else begin
      cnt <= (read_prom_req || write_prom_req) ? cnt + 1 : 0;
      ctl_read_done <= read_prom_req && cnt == DLY;
      ctl_prog_done <= write_prom_req && !read_prom_req && cnt == DLY;
      ctl_read_data <= (cnt == DLY) ? prom_address[7:0] ^ 8'h5a : ~ctl_read_data;
    end
  end
  // Outcome flags
  assign program_done_ok = !fail_mode;
  assign program_failure = fail_mode;
  assign ctl_errors = fail_mode ? 5'h15 : 5'h00;
endmodule : prom_ctl_model

// ### verif/tb_programmer_port_map.sv
// Testbench for the programmer port map: host port reads and writes.
// Assumes the controller model answers requests after a fixed delay.
`timescale 1ns/1ps
module tb_programmer_port_map;
  logic mclk, resetn, ce, io_rd_n, io_wr_n, read_ack_n, fail_mode;
  logic [15:0] io_addr;
  logic [7:0] host_write_bus_n, host_read_bus_n, prom_write_data, ctl_read_data;
  logic [11:0] prom_address;
  logic [3:0] program_nibble;
  logic [4:0] ctl_errors;
  logic nibble_select, socket1_select, socket2_select, read_prom_req, write_prom_req;
  logic ctl_read_done, ctl_prog_done, program_done_ok, program_failure;
  int compares = 0;
  int miscompares = 0;

  programmer_port_map u_programmer_port_map (.mclk(mclk), .resetn(resetn), .ce(ce), .io_addr(io_addr),
    .io_rd_n(io_rd_n), .io_wr_n(io_wr_n), .host_write_bus_n(host_write_bus_n),
    .host_read_bus_n(host_read_bus_n), .read_ack_n(read_ack_n), .prom_write_data(prom_write_data),
    .prom_address(prom_address), .program_nibble(program_nibble), .nibble_select(nibble_select),
    .socket1_select(socket1_select), .socket2_select(socket2_select), .read_prom_req(read_prom_req),
    .write_prom_req(write_prom_req), .ctl_read_done(ctl_read_done), .ctl_read_data(ctl_read_data),
    .ctl_prog_done(ctl_prog_done), .program_done_ok(program_done_ok), .program_failure(program_failure),
    .ctl_errors(ctl_errors));
  prom_ctl_model u_prom_ctl_model (.mclk(mclk), .resetn(resetn), .read_prom_req(read_prom_req),
    .write_prom_req(write_prom_req), .prom_address(prom_address), .fail_mode(fail_mode),
    .ctl_read_done(ctl_read_done), .ctl_read_data(ctl_read_data), .ctl_prog_done(ctl_prog_done),
    .program_done_ok(program_done_ok), .program_failure(program_failure), .ctl_errors(ctl_errors));

  // Clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Host output cycle: data and port held around the strobe
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    io_addr <= a;
    host_write_bus_n <= ~d;
    @(posedge mclk);
    io_wr_n <= 1'b0;
    repeat (4) @(posedge mclk);
    io_wr_n <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask : wr

  // Host input cycle: checks acknowledge, and data when acknowledged
  task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic ack);
    io_addr <= a;
    @(posedge mclk);
    io_rd_n <= 1'b0;
    repeat (5) @(posedge mclk);
    chk({11'h000, read_ack_n}, {11'h000, ack});
    if (ack == 1'b0) chk({4'h0, ~host_read_bus_n}, {4'h0, e});
    io_rd_n <= 1'b1;
    repeat (5) @(posedge mclk);
  endtask : rd

  task automatic finish_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test

  // Watchdog
  initial begin
    #20000;
    miscompares++;
    finish_test();
  end

  // Main sequence
  initial begin
    resetn = 1'b0;
    ce = 1'b1;
    io_addr = 16'h0000;
    io_rd_n = 1'b1;
    io_wr_n = 1'b1;
    host_write_bus_n = 8'hff;
    fail_mode = 1'b0;
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    rd(prog_pkg::PORT_CTRL, 8'h00, 1'b0);
    wr(prog_pkg::PORT_LOW, 8'ha5);
    wr(prog_pkg::PORT_CTRL, 8'h3c);
    chk(prom_address, 12'hca5);
    chk({9'h000, nibble_select, socket1_select, socket2_select}, 12'h006);
    wr(prog_pkg::PORT_DATA, 8'h9e);
    chk({prom_write_data, program_nibble}, 12'h9ee);
    chk({11'h000, write_prom_req}, 12'h001);
    rd(prog_pkg::PORT_CTRL, 8'h01, 1'b0);
    repeat (40) @(posedge mclk);
    rd(prog_pkg::PORT_CTRL, 8'h02, 1'b0);
    wr(prog_pkg::PORT_CTRL, 8'h0a);
    wr(prog_pkg::PORT_DATA, 8'h9e);
    chk({5'h00, program_nibble, nibble_select, socket1_select, socket2_select}, 12'h049);
    repeat (40) @(posedge mclk);
    wr(prog_pkg::PORT_LOW, 8'h33);
    wr(prog_pkg::PORT_CTRL, 8'h45);
    chk({11'h000, read_prom_req}, 12'h001);
    rd(prog_pkg::PORT_CTRL, 8'h01, 1'b0);
    repeat (40) @(posedge mclk);
    chk({11'h000, read_prom_req}, 12'h000);
    rd(prog_pkg::PORT_DATA, 8'h69, 1'b0);
    wr(16'h00f3, 8'hff);
    chk(prom_address, 12'h533);
    rd(16'h00f3, 8'h00, 1'b1);
    fail_mode <= 1'b1;
    wr(prog_pkg::PORT_DATA, 8'h12);
    repeat (40) @(posedge mclk);
    rd(prog_pkg::PORT_CTRL, 8'hac, 1'b0);
    finish_test();
  end
endmodule : tb_programmer_port_map
